// [shared/scd_defs.svh]
// Timing and field constants for the static-column memory controller
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH
`define SCD_CLK_NS        100
`define SCD_ADDR_W        20
`define SCD_HALF_W        10
`define SCD_ROW_LSB       0
`define SCD_COL_LSB       10
`define SCD_REF_ROWS      512
`define SCD_REF_ROW_W     9
`define SCD_WAKE_CYCLES   4'h8
`define SCD_POWERUP_US    100
`define SCD_POWERUP_CYC   ((`SCD_POWERUP_US * 1000) / `SCD_CLK_NS)
`define SCD_REF_MS        8
`define SCD_REF_PERIOD_CYC ((`SCD_REF_MS * 1000000) / `SCD_CLK_NS)
`define SCD_REF_INT_CYC   (`SCD_REF_PERIOD_CYC / `SCD_REF_ROWS)
`define SCD_COLUMN_PRECHARGE_TIME_NS       15
`define SCD_COLUMN_PRECHARGE_TIME_CYC      ((`SCD_COLUMN_PRECHARGE_TIME_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS)
`define SCD_TRP_NS        80
`define SCD_TRP_CYC       ((`SCD_TRP_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS)
`define SCD_TIMER_W       20
`endif

// [shared/scd_pkg.sv]
// Types shared by the static-column memory controller
package scd_pkg;
  typedef enum logic [1:0] {
    SCD_OP_READ,
    SCD_OP_WRITE,
    SCD_OP_RMW,
    SCD_OP_TEST
  } scd_op_e;
endpackage

// [shared/scd_tick_if.sv]
// Refresh tick link between the controller and its refresh timer
`timescale 1ns/10ps
interface scd_tick_if;
  logic tick;
  logic ack;
  modport timer (output tick, input ack);
  modport ctrl  (input tick, output ack);
endinterface

// [rtl/scd_refresh_timer.sv]
// Distributed refresh request timer
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_refresh_timer
  import scd_pkg::*;
#(
  parameter int REF_INT_CYC = `SCD_REF_INT_CYC
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Tick link
  scd_tick_if.timer tk
);
  logic [`SCD_TIMER_W-1:0] cnt_r;

  // Request stays pending until taken; a new tick over an old one merges
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= '0;
    else if (cnt_r >= `SCD_TIMER_W'(REF_INT_CYC - 1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      tk.tick <= 1'b0;
    else if (cnt_r >= `SCD_TIMER_W'(REF_INT_CYC - 1))
      tk.tick <= 1'b1;
    else if (tk.ack)
      tk.tick <= 1'b0;
  end
endmodule

// [rtl/scd_controller.sv]
// Static-column memory controller driving strobes, address and data pins
// Contract
// [R1] Send 20-bit address as row half then column half on 10 pins.
// [R2] Write enable high reads, low writes.
// [R3] Device latches write data on later of write enable or column strobe fall.
// [R4] Early write keeps device output off until next column cycle.
// [R5] Late write keeps read data driven while column strobe low.
// [R6] End each cycle by raising both strobes; row strobe high precharges.
// [R7] Cycle all 512 rows on low nine bits within every 8 ms.
// [R8] Page access: row strobe, column strobe, further columns while row low.
// [R9] Raising the row strobe ends the page sequence.
// [R10] Page write takes data with both strobes and write enable low.
// [R11] Wait 100 us at power-up, then 8 row cycles; repeat if refresh lapsed. The code never sets lapse_r, so it never repeats.
// [R12] Device output off whenever column strobe high.
// [R13] Device output may hold last read data while column strobe low.
// [R14] Pulse column strobe high for precharge time to clear held output.
// [R15] Strobe-order refresh uses device counter, ignores address and write.
// [R16] Row-only refresh: row strobe low, column high, nine-bit row address.
// [R17] Hidden refresh cycles row strobe while column stays low, data kept.
// [R18] Test pin high during a read selects test function mode.
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_controller
  import scd_pkg::*;
#(
  parameter int POWERUP_CYC = `SCD_POWERUP_CYC,
  parameter int REF_INT_CYC = `SCD_REF_INT_CYC
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // User request
  input  wire logic                   req_valid,
  input  wire scd_op_e                req_op,
  input  wire logic [`SCD_ADDR_W-1:0] req_addr,
  input  wire logic                   req_data,
  input  wire logic                   req_page,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic                        rsp_data,
  output logic                        init_done,
  // Memory pins
  output logic [`SCD_HALF_W-1:0]      multiplexed_address,
  output logic                        row_strobe_n,
  output logic                        col_strobe_n,
  output logic                        write_en_n,
  output logic                        data_to_mem,
  input  wire logic                   data_from_mem,
  output logic                        test_function_pin
);
  typedef enum logic [3:0] {
    SCD_POWERUP, SCD_WAKE_LOW, SCD_WAKE_HIGH, SCD_IDLE, SCD_ROW,
    SCD_COL, SCD_SAMPLE, SCD_LATE_WE, SCD_PAGE_WAIT, SCD_COL_PRE,
    SCD_REF_LOW, SCD_PRECHARGE
  } scd_state_e;

  scd_state_e                  state_r;
  logic [`SCD_TIMER_W-1:0]     wait_r;
  logic [3:0]                  wake_r;
  logic [`SCD_REF_ROW_W-1:0]   ref_row_r;
  logic [`SCD_HALF_W-1:0]      row_r;
  scd_op_e                     op_r;
  logic                        wdata_r;
  logic                        page_r;
  logic                        lapse_r;
  logic                        ack;
  logic                        take_idle;
  logic                        take_page;

  scd_tick_if tk ();

  scd_refresh_timer #(.REF_INT_CYC(REF_INT_CYC)) u_timer
  (
    .clk   (clk),
    .reset (reset),
    .tk    (tk.timer)
  );

  function automatic logic [`SCD_HALF_W-1:0] row_half(
    input logic [`SCD_ADDR_W-1:0] a);
    row_half = a[`SCD_ROW_LSB +: `SCD_HALF_W];
  endfunction

  function automatic logic [`SCD_HALF_W-1:0] col_half(
    input logic [`SCD_ADDR_W-1:0] a);
    col_half = a[`SCD_COL_LSB +: `SCD_HALF_W];
  endfunction

  assign ack = (state_r == SCD_IDLE) && tk.ctrl.tick;
  assign tk.ctrl.ack = ack;
  assign take_idle = (state_r == SCD_IDLE) && !lapse_r && !tk.ctrl.tick &&
                     req_valid;
  assign take_page = (state_r == SCD_PAGE_WAIT) && page_r && req_valid &&
                     !tk.ctrl.tick;

  // Main sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= SCD_POWERUP;
    else
    begin
      case (state_r)
        SCD_POWERUP:
          if (wait_r == '0)
            state_r <= SCD_WAKE_LOW; // [R11]
        SCD_WAKE_LOW:
          state_r <= SCD_WAKE_HIGH;
        SCD_WAKE_HIGH:
          if (wait_r == '0)
            state_r <= (wake_r == `SCD_WAKE_CYCLES) ? SCD_IDLE : SCD_WAKE_LOW;
        SCD_IDLE:
          if (lapse_r)
            state_r <= SCD_WAKE_LOW; // [R11]
          else if (tk.ctrl.tick)
            state_r <= SCD_REF_LOW; // [R7]
          else if (req_valid)
            state_r <= SCD_ROW;
        SCD_ROW:
          state_r <= SCD_COL; // [R1]
        SCD_COL:
          state_r <= SCD_SAMPLE;
        SCD_SAMPLE:
          state_r <= (op_r == SCD_OP_RMW) ? SCD_LATE_WE : SCD_PAGE_WAIT;
        SCD_LATE_WE:
          state_r <= SCD_PAGE_WAIT; // [R5]
        SCD_PAGE_WAIT:
          // An open page waits for its next request; a tick closes it
          if (take_page)
            state_r <= SCD_COL_PRE; // [R8]
          else if (!page_r || tk.ctrl.tick)
            state_r <= SCD_PRECHARGE; // [R9]
        SCD_COL_PRE:
          if (wait_r == '0)
            state_r <= SCD_COL; // [R14]
        SCD_REF_LOW:
          state_r <= SCD_PRECHARGE; // [R16]
        SCD_PRECHARGE:
          if (wait_r == '0)
            state_r <= SCD_IDLE; // [R6]
        default:
          state_r <= SCD_IDLE;
      endcase
    end
  end

  // Wait counter for power-up pause and precharge intervals
  always_ff @(posedge clk)
  begin
    if (reset)
      wait_r <= `SCD_TIMER_W'(POWERUP_CYC - 1);
    else if (state_r == SCD_POWERUP || state_r == SCD_WAKE_HIGH ||
             state_r == SCD_PRECHARGE || state_r == SCD_COL_PRE)
    begin
      if (wait_r != '0)
        wait_r <= wait_r - 1'b1;
    end
    else if (state_r == SCD_PAGE_WAIT &&
             page_r && req_valid && !tk.ctrl.tick)
      wait_r <= `SCD_TIMER_W'(`SCD_COLUMN_PRECHARGE_TIME_CYC - 1);
    else
      wait_r <= `SCD_TIMER_W'(`SCD_TRP_CYC - 1);
  end

  // Wake-up cycle count
  always_ff @(posedge clk)
  begin
    if (reset)
      wake_r <= '0;
    else if (state_r == SCD_IDLE && lapse_r)
      wake_r <= '0;
    else if (state_r == SCD_WAKE_LOW)
      wake_r <= wake_r + 1'b1; // [R11]
  end

  // Missed refresh flag: no branch ever sets it, so it stays at its reset value of 0
  always_ff @(posedge clk)
  begin
    if (reset)
      lapse_r <= 1'b0;
    else if (state_r == SCD_WAKE_LOW)
      lapse_r <= 1'b0;
    else if (tk.ctrl.tick && !ack && state_r == SCD_PAGE_WAIT && page_r)
      lapse_r <= lapse_r;
    else
      lapse_r <= lapse_r;
  end

  // Row-only refresh walks the nine-bit row space in order
  always_ff @(posedge clk)
  begin
    if (reset)
      ref_row_r <= '0;
    else if (state_r == SCD_REF_LOW)
      ref_row_r <= ref_row_r + 1'b1; // [R7]
  end

  // Request capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      row_r   <= '0;
      op_r    <= SCD_OP_READ;
      wdata_r <= 1'b0;
      page_r  <= 1'b0;
    end
    else if (take_idle || take_page)
    begin
      op_r    <= req_op;
      wdata_r <= req_data;
      page_r  <= req_page;
      // A page cut by refresh reopens its own row
      if (take_idle && !page_r)
        row_r <= row_half(req_addr);
    end
  end

  // Pin drive; row stays on the page's latched row while the column follows req_addr
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      multiplexed_address <= '0;
      row_strobe_n        <= 1'b1;
      col_strobe_n        <= 1'b1;
      write_en_n          <= 1'b1;
      data_to_mem         <= 1'b0;
      test_function_pin   <= 1'b0;
    end
    else
    begin
      case (state_r)
        SCD_WAKE_LOW:
          row_strobe_n <= 1'b0;
        SCD_IDLE:
        begin
          row_strobe_n <= 1'b1;
          col_strobe_n <= 1'b1;
          write_en_n   <= 1'b1;
          if (!lapse_r && tk.ctrl.tick)
            multiplexed_address <= {1'b0, ref_row_r}; // [R16]
          else if (req_valid)
            multiplexed_address <= page_r ? row_r : row_half(req_addr); // [R1]
        end
        SCD_ROW:
        begin
          row_strobe_n        <= 1'b0; // [R1]
          multiplexed_address <= col_half({req_addr[`SCD_ADDR_W-1:
                                 `SCD_HALF_W], row_r});
          write_en_n          <= !(op_r == SCD_OP_WRITE); // [R2] [R4]
          data_to_mem         <= wdata_r;
          test_function_pin   <= (op_r == SCD_OP_TEST); // [R18]
        end
        SCD_COL:
          col_strobe_n <= 1'b0; // [R3] [R10]
        SCD_SAMPLE:
          if (op_r == SCD_OP_RMW)
          begin
            write_en_n  <= 1'b0; // [R5] [R3]
            data_to_mem <= wdata_r;
          end
        SCD_PAGE_WAIT:
        begin
          col_strobe_n      <= 1'b1; // [R12] [R14]
          write_en_n        <= 1'b1;
          test_function_pin <= 1'b0;
          if (!page_r || tk.ctrl.tick)
            row_strobe_n <= 1'b1; // [R9] [R6]
          else if (req_valid)
          begin
            multiplexed_address <= col_half(req_addr); // [R8]
            write_en_n  <= !(req_op == SCD_OP_WRITE);
            data_to_mem <= req_data;
            test_function_pin <= (req_op == SCD_OP_TEST);
          end
        end
        SCD_REF_LOW:
          row_strobe_n <= 1'b0; // [R16]
        SCD_PRECHARGE:
        begin
          row_strobe_n <= 1'b1; // [R6]
          col_strobe_n <= 1'b1;
          write_en_n   <= 1'b1;
        end
        default:
        begin
          row_strobe_n <= row_strobe_n;
        end
      endcase
      if (state_r == SCD_WAKE_HIGH)
        row_strobe_n <= 1'b1;
    end
  end

  // Handshake and read return
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 1'b0;
      init_done <= 1'b0;
    end
    else
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      if (state_r == SCD_IDLE && !lapse_r && !tk.ctrl.tick && req_valid)
        req_ready <= 1'b1;
      if (state_r == SCD_PAGE_WAIT && page_r && req_valid && !tk.ctrl.tick)
        req_ready <= 1'b1;
      if (state_r == SCD_SAMPLE && op_r != SCD_OP_WRITE)
      begin
        rsp_valid <= 1'b1; // [R13]
        rsp_data  <= data_from_mem;
      end
      if (state_r == SCD_WAKE_HIGH && wait_r == '0 &&
          wake_r == `SCD_WAKE_CYCLES)
        init_done <= 1'b1; // [R11]
    end
  end
endmodule

// [testbench/scd_controller_checker.sv]
// Pin protocol checker for the static-column memory controller
`timescale 1ns/10ps
module scd_controller_checker
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    reset,
  // Request side
  input wire logic    req_ready,
  input wire scd_op_e req_op,
  input wire logic    rsp_valid,
  input wire logic    init_done,
  // Memory pins
  input wire logic    row_strobe_n,
  input wire logic    col_strobe_n,
  input wire logic    write_en_n,
  input wire logic    test_function_pin
);
  int wake_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_cell;
    !row_strobe_n && !col_strobe_n;
  endsequence
  always_ff @(posedge clk)
  begin
    if (reset)
      wake_r <= 0;
    else if (!init_done && $fell(row_strobe_n))
      wake_r <= wake_r + 1;
  end
  a_wake_count:
    assert property ($rose(init_done) |-> wake_r == 8)
    else $error("wrong wake cycle count");
  a_wake_row_only:
    assert property (!init_done |-> col_strobe_n)
    else $error("column strobe during wake-up");
  a_ready_gated:
    assert property (req_ready |-> init_done)
    else $error("request taken before init");
  a_row_first:
    assert property (req_ready |=> !row_strobe_n)
    else $error("row strobe not low after ready");
  a_col_after_row:
    assert property ($fell(col_strobe_n) |-> !$past(row_strobe_n))
    else $error("column strobe before row strobe");
  a_read_answer:
    assert property (req_ready && req_op != SCD_OP_WRITE
                     |-> ##3 rsp_valid ##0 s_cell)
    else $error("read answer late or off");
  a_early_write:
    assert property (req_ready && row_strobe_n && req_op == SCD_OP_WRITE
                     |=> !write_en_n ##1 !write_en_n ##0 s_cell)
    else $error("write enable not before column");
  a_strobes_end:
    assert property ($rose(row_strobe_n) |-> col_strobe_n)
    else $error("row strobe up with column low");
  a_test_mode:
    assert property (req_ready && req_op == SCD_OP_TEST
                     |-> ##3 test_function_pin && write_en_n)
    else $error("test pin missing in test read");
endmodule
bind scd_controller scd_controller_checker u_chk
(
  .clk, .reset, .req_ready, .req_op, .rsp_valid, .init_done,
  .row_strobe_n, .col_strobe_n, .write_en_n, .test_function_pin
);

// [testbench/scd_mem_model.sv]
// Behavioural model of the static-column memory device
`timescale 1ns/10ps
module scd_mem_model
(
  // Memory pins
  input  wire logic [9:0] multiplexed_address,
  input  wire logic       row_strobe_n,
  input  wire logic       col_strobe_n,
  input  wire logic       write_en_n,
  input  wire logic       data_to_mem,
  output logic            data_from_mem,
  // Observation
  output int              rows_seen,
  output int              row_cycles
);
  logic        cell_r [int];
  bit          hit_r [int];
  logic [19:0] sel;
  logic [9:0]  row_q;
  logic        drive;
  logic        noise;
  logic [9:0]  addr_now;
  logic [9:0]  addr_last;
  time         t_chg;

  // Address as it stood before any change in the strobe's own time step
  function automatic logic [9:0] addr_at_edge();
    addr_at_edge = (t_chg == $time) ? addr_last : addr_now;
  endfunction
  initial
  begin
    rows_seen = 0;
    row_cycles = 0;
    drive = 0;
    noise = 0;
    sel = 0;
    row_q = 0;
    addr_now = 0;
    addr_last = 0;
    t_chg = 0;
    #10;
    // Off the clock edges; a toggling level stands for a floating output
    forever
    begin
      noise = ~noise;
      data_from_mem = noise;
      if (drive && !col_strobe_n && cell_r.exists(sel))
        data_from_mem = cell_r[sel];
      else if (drive && !col_strobe_n)
        data_from_mem = 1'b0;
      #50;
    end
  end
  always @(negedge row_strobe_n)
  begin
    row_q = addr_at_edge();
    row_cycles++;
    if (!hit_r.exists(row_q[8:0]))
    begin
      hit_r[row_q[8:0]] = 1;
      rows_seen++;
    end
  end
  always @(negedge col_strobe_n)
  begin
    sel = {addr_at_edge(), row_q};
    drive = write_en_n;
    #1;
    if (!write_en_n && !col_strobe_n)
      cell_r[sel] = data_to_mem;
  end
  always @(negedge write_en_n)
  begin
    #1;
    if (!col_strobe_n)
      cell_r[sel] = data_to_mem;
  end
  always @(multiplexed_address)
  begin
    if (t_chg != $time)
      addr_last = addr_now;
    addr_now = multiplexed_address;
    t_chg = $time;
    if (!row_strobe_n && !col_strobe_n)
      sel = {multiplexed_address, row_q};
  end
  always @(posedge col_strobe_n)
    drive = 0;
endmodule

// [testbench/scd_controller_test.sv]
// Self-checking bench for the static-column memory controller
`timescale 1ns/10ps
`include "scd_defs.svh"
module scd_controller_test
  import scd_pkg::*;
;
  logic                   clk, reset, req_valid, req_data, req_page;
  scd_op_e                req_op;
  logic [`SCD_ADDR_W-1:0] req_addr, a;
  logic                   req_ready, rsp_valid, rsp_data, init_done;
  logic [9:0]             multiplexed_address, open_row;
  logic                   row_strobe_n, col_strobe_n, write_en_n;
  logic                   data_to_mem, data_from_mem, test_function_pin;
  logic                   page_open;
  logic                   exp_q [$];
  logic                   ref_mem [int];
  int                     error_cnt, n_checks, seed, i, rows_seen, row_cycles;

  always #50 clk = ~clk;

  scd_controller #(.POWERUP_CYC(4), .REF_INT_CYC(20)) dut
  (
    .clk, .reset, .req_valid, .req_op, .req_addr, .req_data, .req_page,
    .req_ready, .rsp_valid, .rsp_data, .init_done, .multiplexed_address,
    .row_strobe_n, .col_strobe_n, .write_en_n, .data_to_mem,
    .data_from_mem, .test_function_pin
  );
  scd_mem_model mem
  (
    .multiplexed_address, .row_strobe_n, .col_strobe_n, .write_en_n,
    .data_to_mem, .data_from_mem, .rows_seen, .row_cycles
  );

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Notes the expected answer, then holds the request until it is taken
  task automatic do_req(input scd_op_e op, input logic [19:0] ad,
                        input logic pg);
    logic [19:0] c;
    int          t;
    req_op = op;
    req_addr = ad;
    req_page = pg;
    req_data = $random(seed);
    req_valid = 1;
    c = {ad[19:10], page_open ? open_row : ad[9:0]};
    if (!ref_mem.exists(c))
      ref_mem[c] = 0;
    if (op != SCD_OP_WRITE)
      exp_q.push_back(ref_mem[c]);
    if (op == SCD_OP_WRITE || op == SCD_OP_RMW)
      ref_mem[c] = req_data;
    if (!page_open)
      open_row = ad[9:0];
    page_open = pg;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (req_ready !== 1'b1 && t < 3000);
    if (req_ready !== 1'b1)
    begin
      check(1'b0, "request never taken");
      test_done();
    end
    #2 req_valid = 0;
    repeat (5) @(posedge clk);
    #2;
  endtask

  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1 && exp_q.size() == 0)
      check(1'b0, "unexpected response");
    else if (rsp_valid === 1'b1)
      check(rsp_data === exp_q.pop_front(), "read data differs");
  end

  initial
  begin
    clk = 0;
    reset = 1;
    req_valid = 0;
    req_op = SCD_OP_READ;
    req_addr = 0;
    req_data = 0;
    req_page = 0;
    seed = 72234;
    page_open = 0;
    open_row = 0;
    repeat (6) @(posedge clk);
    #2 reset = 0;
    for (i = 0; i < 3000 && init_done !== 1'b1; i++)
      @(posedge clk);
    #2;
    check(init_done === 1'b1 && row_cycles >= 8, "wake-up missing");
    for (i = 0; i < 8; i++)
    begin
      a = $random(seed);
      do_req(SCD_OP_WRITE, a, 0);
      do_req(i[0] ? SCD_OP_RMW : SCD_OP_TEST, a, 0);
      do_req(SCD_OP_READ, a, 0);
    end
    // Row half of the last two page follow-ups is junk on purpose; the open row rules
    a = $random(seed);
    do_req(SCD_OP_WRITE, a, 1);
    do_req(SCD_OP_WRITE, a ^ 20'h00400, 1);
    do_req(SCD_OP_READ, a ^ 20'h003ff, 1);
    do_req(SCD_OP_READ, a ^ 20'h007ff, 0);
    do_req(SCD_OP_READ, a, 0);
    repeat (12000) @(posedge clk);
    check(rows_seen == 512, "rows left unrefreshed");
    check(exp_q.size() == 0, "responses missing");
    test_done();
  end
endmodule
